// [core/dlr_bank.sv]
// dac load control, interrupt masks and temperature offset registers
`timescale 1ns/10ps
`default_nettype none
`include "dlr_map.svh"
// Function
// - load bits 0-3 update only their dac
// - load bits honoured only in register mode
// - load bits self-clear, read back zero
// - bit 4 picks reference for dacs a,b
// - bit 5 picks reference for dacs c,d
// - first mask bits 0-4 block temperature sources
// - first mask bits 5-7 block analog inputs 2-4
// - second mask bit 4 blocks supply interrupts
// - internal offset added to internal result
// - external offset added to external result
// - analog offset shifts dac a temperature
// - dac a temperature saturates outside span
// - control bit 3 hands loading to registers
// - mode 11 with control bit 3 set takes loads from register only
module dlr_bank import dlr_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire dlr_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic dac_load_strobe_n,
	input wire dlr_meas_t int_meas,
	input wire dlr_meas_t ext_meas,
	input wire logic [7:0] alert_src,
	input wire logic vdd_alert_src,
	output logic alert_out,
	output dlr_res_t int_result,
	output dlr_res_t ext_result,
	output logic [7:0] dac_a_temp_code,
	output logic [3:0][7:0] dac_out_code,
	output logic ref_int_ab,
	output logic ref_int_cd,
	output logic irq_out
);
	dlr_state_all_t s_q; // registered state
	dlr_state_all_t s_d; // next state
	logic reg_mode; // register-driven loading selected
	logic pin_fall; // synchronised strobe pin fell
	logic [3:0] irq_ev; // interrupt events
	logic [10:0] sum_int; // wide internal sum
	logic [10:0] sum_ext; // wide external sum
	logic [8:0] sum_ana; // wide dac a sum
	logic [3:0] load_now; // dacs loaded this cycle

	// sign-extend an 8-bit offset to the 11-bit sum width
	function automatic logic [10:0] sx8(input logic [7:0] v);
		sx8 = {{3{v[7]}}, v};
	endfunction

	// decode and next-state logic
	always_comb begin
		s_d = s_q;
		reg_mode = s_q.ctrl3[`DLR_BIT_PIN_OFF] &&
			(s_q.dac_cfg[5:4] == `DLR_LOAD_MODE_REG);
		pin_fall = s_q.strobe_prev & ~s_q.strobe_s[1];
		load_now = 4'h0;
		irq_ev = 4'h0;
		// offsets applied to the results
		sum_int = {int_meas.temp[9], int_meas.temp} +
			(sx8(s_q.int_off) << 2);
		sum_ext = {ext_meas.temp[9], ext_meas.temp} +
			(sx8(s_q.ext_off) << 2);
		// dac a path in whole degrees
		sum_ana = {s_q.int_res.temp[9], s_q.int_res.temp[9:2]} +
			{s_q.ana_off[7], s_q.ana_off};
		// strobe synchroniser
		s_d.strobe_s = {s_q.strobe_s[0], dac_load_strobe_n};
		s_d.strobe_prev = s_q.strobe_s[1];
		s_d.rdata = 8'h00;
		s_d.int_res.vld = 1'b0;
		s_d.ext_res.vld = 1'b0;
		s_d.load_ctrl[3:0] = 4'h0;
		s_d.st = DLR_IDLE;
		// store corrected results
		if (int_meas.vld) begin
			s_d.int_res.temp = sum_int[9:0];
			s_d.int_res.vld = 1'b1;
		end
		if (ext_meas.vld) begin
			s_d.ext_res.temp = sum_ext[9:0];
			s_d.ext_res.vld = 1'b1;
		end
		// saturate dac a temperature
		if (sum_ana[8] != sum_ana[7]) begin
			s_d.dac_a_temp = sum_ana[8] ? 8'h80 : 8'h7F;
		end else begin
			s_d.dac_a_temp = sum_ana[7:0];
		end
		// pending loads from the register or from the pin
		if (s_q.st == DLR_LOAD) begin
			load_now = s_q.pend;
		end
		if (!s_q.ctrl3[`DLR_BIT_PIN_OFF] && pin_fall) begin
			load_now = 4'hF;
		end
		// move buffer to output for loaded dacs
		for (int i = 0; i < 4; i++) begin
			if (load_now[i]) begin
				s_d.out_r[i] = s_q.buf_r[i];
			end
		end
		irq_ev = load_now;
		s_d.pend = 4'h0;
		// register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				`DLR_OFF_LOAD_CTRL: begin
					s_d.load_ctrl = bus_req.wdata & `DLR_LOAD_CTRL_KEEP;
					if (reg_mode) begin
						s_d.pend = bus_req.wdata[3:0];
						s_d.st = DLR_LOAD;
					end
				end
				`DLR_OFF_MASK_FIRST: s_d.mask1 = bus_req.wdata;
				`DLR_OFF_MASK_SECOND:
					s_d.mask2 = bus_req.wdata & `DLR_MASK_SECOND_KEEP;
				`DLR_OFF_INT_OFFSET: s_d.int_off = bus_req.wdata;
				`DLR_OFF_EXT_OFFSET: s_d.ext_off = bus_req.wdata;
				`DLR_OFF_ANA_OFFSET: s_d.ana_off = bus_req.wdata;
				`DLR_OFF_DAC_CFG: s_d.dac_cfg = bus_req.wdata;
				`DLR_OFF_CTRL_CFG3: s_d.ctrl3 = bus_req.wdata;
				`DLR_OFF_IRQ_MASK: s_d.irq_mk = bus_req.wdata[3:0];
				default: begin
				end
			endcase
			// buffer registers of the four dacs
			if (bus_req.addr[7:2] == `DLR_OFF_BUF_BASE >> 2) begin
				s_d.buf_r[bus_req.addr[1:0]] = bus_req.wdata;
			end
		end
		// sticky status: set wins over write-one clear
		if (bus_req.wr && bus_req.addr == `DLR_OFF_IRQ_STATUS) begin
			s_d.irq_st = s_q.irq_st & ~bus_req.wdata[3:0];
		end
		s_d.irq_st = s_d.irq_st | irq_ev;
		// register reads, answer next cycle
		if (bus_req.rd) begin
			case (bus_req.addr)
				// command bits always read back as zero
				`DLR_OFF_LOAD_CTRL: s_d.rdata = {s_q.load_ctrl[7:4], 4'h0};
				`DLR_OFF_MASK_FIRST: s_d.rdata = s_q.mask1;
				`DLR_OFF_MASK_SECOND: s_d.rdata = s_q.mask2;
				`DLR_OFF_INT_OFFSET: s_d.rdata = s_q.int_off;
				`DLR_OFF_EXT_OFFSET: s_d.rdata = s_q.ext_off;
				`DLR_OFF_ANA_OFFSET: s_d.rdata = s_q.ana_off;
				`DLR_OFF_DAC_CFG: s_d.rdata = s_q.dac_cfg;
				`DLR_OFF_CTRL_CFG3: s_d.rdata = s_q.ctrl3;
				`DLR_OFF_IRQ_STATUS: s_d.rdata = {4'h0, s_q.irq_st};
				`DLR_OFF_IRQ_MASK: s_d.rdata = {4'h0, s_q.irq_mk};
				default: begin
					if (bus_req.addr[7:2] == `DLR_OFF_OUT_BASE >> 2) begin
						s_d.rdata = s_q.out_r[bus_req.addr[1:0]];
					end else if (bus_req.addr[7:2] == `DLR_OFF_BUF_BASE >> 2) begin
						s_d.rdata = s_q.buf_r[bus_req.addr[1:0]];
					end
				end
			endcase
		end
	end

	// state register with clock enable
	// the whole bank freezes while clk_en is low, including the pin
	// synchroniser, so a strobe pulse that starts and ends within a freeze is lost;
	// a strobe still low when the enable returns is only seen late
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= DLR_IDLE;
			s_q.ana_off <= `DLR_RST_ANA_OFFSET;
			s_q.strobe_s <= 2'b11;
			s_q.strobe_prev <= 1'b1;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// alert gating by the two mask registers
	assign alert_out = |(alert_src & ~s_q.mask1) |
		(vdd_alert_src & ~s_q.mask2[`DLR_BIT_VDD_MASK]);
	assign irq_out = |(s_q.irq_st & s_q.irq_mk);
	assign bus_rdata = s_q.rdata;
	assign int_result = s_q.int_res;
	assign ext_result = s_q.ext_res;
	assign dac_a_temp_code = s_q.dac_a_temp;
	assign dac_out_code = s_q.out_r;
	assign ref_int_ab = s_q.load_ctrl[`DLR_BIT_REF_AB];
	assign ref_int_cd = s_q.load_ctrl[`DLR_BIT_REF_CD];

	// load bits never read back as ones
	load_selfclear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_q.load_ctrl[3:0] == 4'h0) else $error("load bits stuck");
	// register load leaves dac a alone unless it is selected
	load_select_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && bus_req.wr && bus_req.addr == `DLR_OFF_LOAD_CTRL && reg_mode
		&& !bus_req.wdata[0] ##1 clk_en && s_q.ctrl3[`DLR_BIT_PIN_OFF]
		|=> $stable(s_q.out_r[0])) else $error("dac a loaded unasked");
	// load refused outside register mode
	load_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && bus_req.wr && bus_req.addr == `DLR_OFF_LOAD_CTRL && !reg_mode
		|=> s_q.pend == 4'h0) else $error("load taken in wrong mode");
	// reference bits follow the written value
	ref_select_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && bus_req.wr && bus_req.addr == `DLR_OFF_LOAD_CTRL
		|=> ref_int_ab == $past(bus_req.wdata[4]) &&
		ref_int_cd == $past(bus_req.wdata[5])) else $error("ref wrong");
	// masked first sources never raise alert
	mask_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(alert_src & ~s_q.mask1) == 8'h00 && !vdd_alert_src |-> !alert_out)
		else $error("masked source alerted");
	// supply alert blocked by second mask
	mask_vdd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		alert_src == 8'h00 && vdd_alert_src |->
		alert_out == !s_q.mask2[`DLR_BIT_VDD_MASK]) else $error("vdd mask");
	// internal result carries the offset
	int_offset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && int_meas.vld |=> int_result.temp ==
		$past(int_meas.temp) + {$past(s_q.int_off), 2'b00})
		else $error("internal offset wrong");
	// dac a temperature clamps at the bottom of span
	dac_sat_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && sum_ana[8] && !sum_ana[7] |=> dac_a_temp_code == 8'h80)
		else $error("dac a not saturated");
	// pin strobe loads only in pin mode
	pin_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && s_q.ctrl3[`DLR_BIT_PIN_OFF] && s_q.st == DLR_IDLE
		|=> $stable(dac_out_code)) else $error("pin load in reg mode");

	// second reference bit follows the written value
	// dacs c and d switch reference one cycle after the write
	ref_cd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && bus_req.wr && bus_req.addr == `DLR_OFF_LOAD_CTRL
		|=> ref_int_cd == $past(bus_req.wdata[5]))
		else $error("second reference wrong");

	// unmasked temperature source always raises alert
	// alert is combinational, so it follows the source at once
	mask_temp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(alert_src[4:0] & ~s_q.mask1[4:0]) != 5'h00 |-> alert_out)
		else $error("temperature alert lost");

	// unmasked analog input always raises alert
	// bits 5 to 7 stand for analog inputs 2 to 4
	mask_analog_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(alert_src[7:5] & ~s_q.mask1[7:5]) != 3'h0 |-> alert_out)
		else $error("analog alert lost");

	// reserved bits of the second mask stay zero
	// only the supply mask bit is kept
	vdd_reserved_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_q.mask2 & ~`DLR_MASK_SECOND_KEEP) == 8'h00)
		else $error("second mask reserved set");

	// external result carries its offset
	// offset is whole degrees, result is quarter degrees
	ext_offset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && ext_meas.vld |=> ext_result.temp ==
		$past(ext_meas.temp) + {$past(s_q.ext_off), 2'b00})
		else $error("external offset wrong");

	// in-span dac a temperature is the plain sum
	// the analog offset moves zero volts along the scale
	ana_offset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && sum_ana[8] == sum_ana[7]
		|=> dac_a_temp_code == $past(sum_ana[7:0]))
		else $error("analog offset wrong");

	// dac a temperature clamps at the top of span
	// overflow above plus 127 degrees gives the code 7F
	dac_sat_hi_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && !sum_ana[8] && sum_ana[7] |=> dac_a_temp_code == 8'h7F)
		else $error("dac a not clamped high");

	// register command arms exactly the written bits
	// pending bits are consumed in the following cycle
	load_pend_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && bus_req.wr && bus_req.addr == `DLR_OFF_LOAD_CTRL && reg_mode
		|=> s_q.pend == $past(bus_req.wdata[3:0]))
		else $error("load bits not armed");

	// load field other than 11 arms nothing
	// the other field codes belong to data writes, not here
	mode_field_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && bus_req.wr && bus_req.addr == `DLR_OFF_LOAD_CTRL &&
		s_q.ctrl3[`DLR_BIT_PIN_OFF] &&
		s_q.dac_cfg[5:4] != `DLR_LOAD_MODE_REG
		|=> s_q.pend == 4'h0) else $error("load armed in wrong field");

	// armed load copies the buffer of dac a
	// the output keeps its code until this moment
	reg_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && s_q.st == DLR_LOAD && s_q.pend[0]
		|=> dac_out_code[0] == $past(s_q.buf_r[0]))
		else $error("dac a load missed");

	// armed load copies the buffer of dac d
	// checks the far end of the output array
	reg_load_d_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && s_q.st == DLR_LOAD && s_q.pend[3]
		|=> dac_out_code[3] == $past(s_q.buf_r[3]))
		else $error("dac d load missed");

	// pin strobe in pin mode loads all four
	// the edge is seen two flops after the pin falls
	pin_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && !s_q.ctrl3[`DLR_BIT_PIN_OFF] && pin_fall
		|=> dac_out_code == $past(s_q.buf_r))
		else $error("pin load missed");
endmodule
`default_nettype wire

// [core/dlr_map.svh]
// register offsets, field positions and reset values of the dac load bank
`ifndef DLR_MAP_SVH
`define DLR_MAP_SVH
`define DLR_OFF_LOAD_CTRL 8'h1C
`define DLR_OFF_MASK_FIRST 8'h1D
`define DLR_OFF_MASK_SECOND 8'h1E
`define DLR_OFF_INT_OFFSET 8'h1F
`define DLR_OFF_EXT_OFFSET 8'h20
`define DLR_OFF_ANA_OFFSET 8'h21
`define DLR_OFF_DAC_CFG 8'h1B
`define DLR_OFF_CTRL_CFG3 8'h1A
`define DLR_OFF_IRQ_STATUS 8'h40
`define DLR_OFF_IRQ_MASK 8'h41
`define DLR_OFF_BUF_BASE 8'h44
`define DLR_OFF_OUT_BASE 8'h48
`define DLR_RST_ZERO 8'h00
`define DLR_RST_ANA_OFFSET 8'hD8
`define DLR_BIT_REF_AB 4
`define DLR_BIT_REF_CD 5
`define DLR_BIT_PIN_OFF 3
`define DLR_BIT_VDD_MASK 4
`define DLR_LOAD_MODE_REG 2'h3
`define DLR_MASK_SECOND_KEEP 8'h10
`define DLR_LOAD_CTRL_KEEP 8'h30
`define DLR_IRQ_BITS 4
`endif

// [core/dlr_pkg.sv]
// types shared by the dac load bank
package dlr_pkg;
	// host register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dlr_bus_req_t;
	// raw measurement input with its valid strobe
	typedef struct packed {
		logic [9:0] temp;
		logic vld;
	} dlr_meas_t;
	// corrected measurement output
	typedef struct packed {
		logic [9:0] temp;
		logic vld;
	} dlr_res_t;
	// load sequencer states
	typedef enum logic [1:0] {
		DLR_IDLE = 2'b01,
		DLR_LOAD = 2'b10
	} dlr_state_t;
	// whole state of the bank
	typedef struct packed {
		dlr_state_t st;
		logic [7:0] load_ctrl;
		logic [7:0] mask1;
		logic [7:0] mask2;
		logic [7:0] int_off;
		logic [7:0] ext_off;
		logic [7:0] ana_off;
		logic [7:0] dac_cfg;
		logic [7:0] ctrl3;
		logic [3:0] pend;
		logic [3:0] irq_st;
		logic [3:0] irq_mk;
		logic [3:0][7:0] buf_r;
		logic [3:0][7:0] out_r;
		logic [7:0] rdata;
		dlr_res_t int_res;
		dlr_res_t ext_res;
		logic [7:0] dac_a_temp;
		logic [1:0] strobe_s;
		logic strobe_prev;
	} dlr_state_all_t;
endpackage

// [verif/dlr_bank_bench.sv]
// self-checking bench for the dac load bank
`timescale 1ns/10ps
`default_nettype none
`include "dlr_map.svh"
module dlr_bank_bench;
	import dlr_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic strobe_n = 1'b1; // pin load strobe, idle high
	logic clk_en = 1'b1; // bank clock enable
	logic [7:0] dac_a; // dac a temperature code
	dlr_meas_t int_meas = '0;
	dlr_meas_t ext_meas = '0;
	logic [7:0] alert_src = 8'h00;
	logic vdd_src = 1'b0;
	dlr_bus_req_t bus_req;
	logic [7:0] bus_rdata, rsp_data;
	logic rsp_vld, alert_out, ref_ab, ref_cd, irq_out;
	dlr_res_t int_result, ext_result;
	logic [9:0] rq[$]; // expected read data
	logic [9:0] mq[$]; // expected corrected results
	int fail_count = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'h1E556338;
	logic [31:0] r;
	logic [7:0] bufv[4]; // codes placed in the buffers
	logic [7:0] off;
	logic [9:0] t;
	always #5 sys_clk = ~sys_clk;
	dlr_host u_host (.sys_clk(sys_clk), .bus_rdata(bus_rdata),
		.bus_req(bus_req), .rsp_vld(rsp_vld), .rsp_data(rsp_data));
	dlr_bank u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.bus_req(bus_req), .bus_rdata(bus_rdata),
		.dac_load_strobe_n(strobe_n), .int_meas(int_meas),
		.ext_meas(ext_meas), .alert_src(alert_src),
		.vdd_alert_src(vdd_src), .alert_out(alert_out),
		.int_result(int_result), .ext_result(ext_result),
		.dac_a_temp_code(dac_a), .dac_out_code(), .ref_int_ab(ref_ab),
		.ref_int_cd(ref_cd), .irq_out(irq_out));
	// xorshift source for stimulus
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d);
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back({2'b00, e});
		u_host.xfer(1'b0, a, 8'h00);
	endtask
	task automatic finish_test();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// watcher: match each result with the oldest note
	always @(posedge sys_clk) begin
		if (rsp_vld === 1'b1) check({2'b00, rsp_data}, rq.pop_front());
		if (int_result.vld === 1'b1) check(int_result.temp, mq.pop_front());
		if (ext_result.vld === 1'b1) check(ext_result.temp, mq.pop_front());
	end
	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// reset values, then an unmapped address
		for (int i = 0; i < 6; i++) reg_rd(8'h1C + i[7:0], i == 5 ? 8'hD8 : 8'h00);
		reg_rd(8'h30, 8'h00);
		// a write while frozen is not taken
		clk_en <= 1'b0;
		reg_wr(`DLR_OFF_INT_OFFSET, 8'h55);
		clk_en <= 1'b1;
		reg_rd(`DLR_OFF_INT_OFFSET, 8'h00);
		// masks gate the alert output
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			reg_wr(`DLR_OFF_MASK_FIRST, r[7:0]);
			reg_wr(`DLR_OFF_MASK_SECOND, {3'b000, r[8], 4'h0});
			alert_src <= r[23:16];
			vdd_src <= r[24];
			reg_rd(`DLR_OFF_MASK_FIRST, r[7:0]);
			reg_rd(`DLR_OFF_MASK_SECOND, {3'b000, r[8], 4'h0});
			check({9'h000, alert_out}, {9'h000, |(r[23:16] & ~r[7:0]) | (r[24] & ~r[8])});
		end
		// pin mode: register loads ignored, reference bits kept
		for (int i = 0; i < 4; i++) begin
			bufv[i] = rnd();
			reg_wr(`DLR_OFF_BUF_BASE + i[7:0], bufv[i]);
		end
		reg_wr(`DLR_OFF_LOAD_CTRL, 8'h1F);
		reg_rd(`DLR_OFF_LOAD_CTRL, 8'h10);
		check({9'h000, ref_ab}, 10'h001);
		check({9'h000, ref_cd}, 10'h000);
		reg_rd(`DLR_OFF_OUT_BASE, 8'h00);
		// register mode but load field not 11
		reg_wr(`DLR_OFF_CTRL_CFG3, 8'h08);
		reg_wr(`DLR_OFF_DAC_CFG, 8'h20);
		reg_wr(`DLR_OFF_LOAD_CTRL, 8'h04);
		reg_rd(`DLR_OFF_OUT_BASE + 8'h02, 8'h00);
		// full register mode: only dac b moves
		reg_wr(`DLR_OFF_DAC_CFG, 8'h30);
		reg_wr(`DLR_OFF_IRQ_MASK, 8'h02);
		reg_wr(`DLR_OFF_LOAD_CTRL, 8'h22);
		repeat (3) @(posedge sys_clk);
		check({9'h000, irq_out}, 10'h001);
		check({8'h00, ref_ab, ref_cd}, 10'h001);
		reg_rd(`DLR_OFF_OUT_BASE, 8'h00);
		reg_rd(`DLR_OFF_OUT_BASE + 8'h01, bufv[1]);
		reg_rd(`DLR_OFF_OUT_BASE + 8'h03, 8'h00);
		reg_wr(`DLR_OFF_IRQ_STATUS, 8'h02);
		repeat (2) @(posedge sys_clk);
		check({9'h000, irq_out}, 10'h000);
		// pin strobe loads all four
		reg_wr(`DLR_OFF_CTRL_CFG3, 8'h00);
		strobe_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		strobe_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		for (int i = 0; i < 4; i++) reg_rd(`DLR_OFF_OUT_BASE + i[7:0], bufv[i]);
		// dac a temperature: clamp, then a plain shift
		reg_wr(`DLR_OFF_ANA_OFFSET, 8'h7F);
		mq.push_back(10'h1FC);
		int_meas <= '{temp: 10'h1FC, vld: 1'b1};
		@(posedge sys_clk);
		int_meas <= '0;
		repeat (3) @(posedge sys_clk);
		check({2'b00, dac_a}, 10'h07F);
		reg_wr(`DLR_OFF_ANA_OFFSET, 8'hF0);
		mq.push_back(10'h0A0);
		int_meas <= '{temp: 10'h0A0, vld: 1'b1};
		@(posedge sys_clk);
		int_meas <= '0;
		repeat (3) @(posedge sys_clk);
		check({2'b00, dac_a}, 10'h018);
		// offsets added to both channels
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			off = {{2{r[5]}}, r[5:0]};
			t = {{2{r[15]}}, r[15:8]};
			reg_wr(`DLR_OFF_INT_OFFSET, off);
			reg_wr(`DLR_OFF_EXT_OFFSET, off);
			reg_rd(`DLR_OFF_EXT_OFFSET, off);
			mq.push_back(t + {off, 2'b00});
			int_meas <= '{temp: t, vld: 1'b1};
			@(posedge sys_clk);
			int_meas <= '0;
			mq.push_back(t + {off, 2'b00});
			ext_meas <= '{temp: t, vld: 1'b1};
			@(posedge sys_clk);
			ext_meas <= '0;
		end
		repeat (5) @(posedge sys_clk);
		finish_test();
	end
endmodule
`default_nettype wire

// [verif/dlr_host.sv]
// host model driving the register port of the dac load bank
`timescale 1ns/10ps
`default_nettype none
`include "dlr_map.svh"
module dlr_host import dlr_pkg::*; (
	input wire logic sys_clk,
	input wire logic [7:0] bus_rdata,
	output dlr_bus_req_t bus_req,
	output logic rsp_vld,
	output logic [7:0] rsp_data
);
	logic rd_q; // read strobe of the last cycle
	initial begin
		bus_req = '0;
		rd_q = 1'b0;
		rsp_vld = 1'b0;
		rsp_data = 8'h00;
	end
	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		rd_q <= bus_req.rd;
		rsp_vld <= rd_q;
		rsp_data <= bus_rdata;
	end
	// one-cycle request; reserved bits of load control and second mask sent as zero
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (w && a == `DLR_OFF_LOAD_CTRL) v = d & 8'h3F;
		if (w && a == `DLR_OFF_MASK_SECOND) v = d & 8'h10;
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: v, wr: w, rd: ~w};
		@(posedge sys_clk);
		bus_req <= '0;
	endtask
endmodule
`default_nettype wire
